// >>> shared/smc_regs.vh
/*
  register map, field positions and timing counts of the suspend mode controller.
  assumes inclusion by bare name from each design file; definitions only.
*/
`ifndef SMC_REGS_VH
`define SMC_REGS_VH
// byte addresses, one aligned word each
`define SMC_ADDR_CTRL 8'h00
`define SMC_ADDR_STATUS 8'h04
`define SMC_ADDR_IRQ_STAT 8'h08
`define SMC_ADDR_IRQ_MASK 8'h0C
`define SMC_ADDR_WAKE_EN 8'h10
`define SMC_ADDR_TIMING 8'h14
`define SMC_ADDR_PIN_MODE 8'h18
// ctrl fields
`define SMC_CTRL_ENABLE 0
`define SMC_CTRL_SYNC 1
`define SMC_CTRL_MULTI 2
`define SMC_CTRL_RESET 32'h0000_0000
// status fields
`define SMC_ST_STATE_LO 0
`define SMC_ST_STATE_HI 2
`define SMC_ST_AWAKE 3
`define SMC_ST_REQ 4
`define SMC_ST_GWE 5
`define SMC_ST_GTS 6
`define SMC_ST_DISABLE 7
// interrupt events
`define SMC_EV_ENTER 0
`define SMC_EV_EXIT 1
`define SMC_EV_REQ 2
`define SMC_EV_W 3
// timing register fields and defaults
`define SMC_TIM_GTS_LO 0
`define SMC_TIM_GTS_HI 3
`define SMC_TIM_GWE_LO 8
`define SMC_TIM_GWE_HI 11
`define SMC_GTS_DEFAULT 4'h4
`define SMC_GWE_DEFAULT 4'h5
`define SMC_CNT_W 4
// axi responses
`define SMC_RESP_OKAY 2'h0
`define SMC_RESP_SLVERR 2'h2
`endif

// >>> verilog/smc_sync.v
/*
  three-stage input synchroniser for W pins; a change is accepted once
  stages two and three agree. assumes an asynchronous pin and one clock.
*/
`timescale 1ns/100ps
`include "smc_regs.vh"
module smc_sync #(
  parameter W = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] pin,
  output wire [W-1:0] level
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] lvl_q;
  // stage one is read only by stage two
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      lvl_q <= {W{1'b0}};
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // agreement filter: hold the old level while stages two and three differ
      lvl_q <= (lvl_q & (s2_q ^ s3_q)) | (s2_q & s3_q);
    end
  end
  assign level = lvl_q;
endmodule // smc_sync

// >>> verilog/smc_wake_timer.v
/*
  wake-up release timer: counts wake-clock cycles after the awake pin rises
  and raises done once the programmed count is reached. assumes run is a
  level from logic on the same clock.
*/
`timescale 1ns/100ps
`include "smc_regs.vh"
module smc_wake_timer #(
  parameter CW = `SMC_CNT_W
) (
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire [CW-1:0] limit,
  output wire done
);
  reg [CW-1:0] cnt_q;
  reg done_q;
  // count stops at the limit; dropping run clears it
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q <= {CW{1'b0}};
      done_q <= 1'b0;
    end else if (!done_q) begin
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      done_q <= ((cnt_q + {{(CW-1){1'b0}}, 1'b1}) >= limit);
    end
  end
  assign done = done_q;
endmodule // smc_wake_timer

// >>> verilog/smc_top.v
/*
  suspend mode controller: sleep entry handshake, write protect, input and
  interconnect shutdown, per-pin sleep output select, awake status, multi-pin
  wake-up and programmable release timers, with an axi4-lite register file.
  assumes one 100 MHz clock and an external controller on the sleep pins.
*/
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "smc_regs.vh"
module smc_top #(
  parameter NWAKE = 8,
  parameter NPIN = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sleep_pin,
  input wire [NWAKE-1:0] wake_control_pins,
  input wire sleep_ack_in,
  output wire sleep_req_out,
  output wire awake_pin,
  output wire config_done,
  output wire write_protect,
  output wire input_disable,
  output wire sleep_outputs_active,
  output wire [NPIN-1:0] pin_sleep_mode,
  output wire irq
);
  // states
  localparam ST_RUN = 3'h0;
  localparam ST_REQ = 3'h1;
  localparam ST_SLEEP = 3'h2;
  localparam ST_WAKE = 3'h3;
  localparam ST_WAKE_EN = 3'h4;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] ctrl_q;
  reg [`SMC_EV_W-1:0] irq_stat_q;
  reg [`SMC_EV_W-1:0] irq_mask_q;
  reg [NWAKE-1:0] wake_en_q;
  reg [`SMC_CNT_W-1:0] gts_cnt_q;
  reg [`SMC_CNT_W-1:0] gwe_cnt_q;
  reg [NPIN-1:0] pin_mode_q;
  reg req_out_q;
  reg awake_q;
  reg wp_q;
  reg dis_q;
  reg gts_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [7:0] awaddr_q;
  reg aw_have_q;
  reg w_have_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  wire sleep_s;
  wire ack_s;
  wire [NWAKE-1:0] wake_s;
  wire gts_done;
  wire gwe_done;
  wire tmr_run;
  wire en = ctrl_q[`SMC_CTRL_ENABLE];
  wire use_sync = ctrl_q[`SMC_CTRL_SYNC];
  wire multi = ctrl_q[`SMC_CTRL_MULTI];
  wire any_wake = |(wake_s & wake_en_q);
  wire [`SMC_EV_W-1:0] ev;
  wire do_write;
  wire [31:0] wmask;

  // pins cross into this clock through three flops and an agreement flop
  smc_sync #(.W(1)) u_sync_sleep (.aclk(aclk), .aresetn(aresetn), .pin(sleep_pin),
    .level(sleep_s));
  smc_sync #(.W(1)) u_sync_ack (.aclk(aclk), .aresetn(aresetn), .pin(sleep_ack_in),
    .level(ack_s));
  smc_sync #(.W(NWAKE)) u_sync_wake (.aclk(aclk), .aresetn(aresetn),
    .pin(wake_control_pins), .level(wake_s));

  // timers are armed in the cycle that raises awake, so a release lands exactly
  // the programmed number of cycles after the awake rise, not one later
  assign tmr_run = (state_q == ST_WAKE) || (state_q == ST_WAKE_EN);
  smc_wake_timer #(.CW(`SMC_CNT_W)) u_gts_tmr (.aclk(aclk), .aresetn(aresetn),
    .run(tmr_run), .limit(gts_cnt_q), .done(gts_done));
  smc_wake_timer #(.CW(`SMC_CNT_W)) u_gwe_tmr (.aclk(aclk), .aresetn(aresetn),
    .run(tmr_run), .limit(gwe_cnt_q), .done(gwe_done));

  // sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (en && sleep_s) begin
          if (use_sync)
            state_d = ST_REQ;
          else
            state_d = ST_SLEEP;
        end
      end
      ST_REQ: begin
        if (!sleep_s || !en)
          state_d = ST_RUN;
        else if (ack_s)
          state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        // multi-pin needs request low and an enabled wake pin high, already high counts
        if (!sleep_s && (!multi || any_wake))
          state_d = ST_WAKE;
      end
      ST_WAKE: begin
        state_d = ST_WAKE_EN;
      end
      ST_WAKE_EN: begin
        if (gts_done && gwe_done)
          state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // sequencer outputs are registered so pins never glitch
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_RUN;
      req_out_q <= 1'b0;
      awake_q <= 1'b1;
      wp_q <= 1'b0;
      dis_q <= 1'b0;
      gts_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_out_q <= (state_d == ST_REQ) || (state_d == ST_SLEEP && use_sync);
      if (state_d == ST_SLEEP) begin
        wp_q <= 1'b1;
        dis_q <= 1'b1;
        gts_q <= 1'b1;
        awake_q <= 1'b0;
      end else if (state_d == ST_WAKE) begin
        dis_q <= 1'b0; // inputs return first, storage still protected
      end else if (state_d == ST_WAKE_EN) begin
        awake_q <= 1'b1;
        if (gts_done)
          gts_q <= 1'b0;
        if (gwe_done)
          wp_q <= 1'b0;
      end else if (state_d == ST_RUN) begin
        wp_q <= 1'b0;
        gts_q <= 1'b0;
        dis_q <= 1'b0;
        awake_q <= 1'b1;
      end
    end
  end

  assign sleep_req_out = req_out_q;
  assign awake_pin = awake_q;
  assign config_done = 1'b1; // configuration never cleared here
  assign write_protect = wp_q;
  assign input_disable = dis_q;
  assign sleep_outputs_active = gts_q;
  assign pin_sleep_mode = pin_mode_q & {NPIN{gts_q}};

  // events: entry, exit complete, request raised
  assign ev[`SMC_EV_ENTER] = (state_d == ST_SLEEP) && (state_q != ST_SLEEP);
  assign ev[`SMC_EV_EXIT] = (state_d == ST_RUN) && (state_q == ST_WAKE_EN);
  assign ev[`SMC_EV_REQ] = (state_d == ST_REQ) && (state_q == ST_RUN);
  assign irq = |(irq_stat_q & irq_mask_q);

  // axi4-lite write path: address and data taken in either order
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // register file and write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `SMC_RESP_OKAY;
      ctrl_q <= `SMC_CTRL_RESET;
      irq_stat_q <= {`SMC_EV_W{1'b0}};
      irq_mask_q <= {`SMC_EV_W{1'b0}};
      wake_en_q <= {NWAKE{1'b0}};
      gts_cnt_q <= `SMC_GTS_DEFAULT;
      gwe_cnt_q <= `SMC_GWE_DEFAULT;
      pin_mode_q <= {NPIN{1'b0}};
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
      // set wins over a write-one clear in the same cycle
      if (do_write && awaddr_q == `SMC_ADDR_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~(wdata_q[`SMC_EV_W-1:0] & wmask[`SMC_EV_W-1:0])) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= `SMC_RESP_OKAY;
        case (awaddr_q)
          `SMC_ADDR_CTRL: ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask & 32'h0000_0007);
          `SMC_ADDR_IRQ_STAT: begin
          end
          `SMC_ADDR_IRQ_MASK: begin
            if (wstrb_q[0])
              irq_mask_q <= wdata_q[`SMC_EV_W-1:0];
          end
          `SMC_ADDR_WAKE_EN: begin
            if (wstrb_q[0])
              wake_en_q <= wdata_q[NWAKE-1:0];
          end
          `SMC_ADDR_TIMING: begin
            if (wstrb_q[0])
              gts_cnt_q <= wdata_q[`SMC_TIM_GTS_HI:`SMC_TIM_GTS_LO];
            if (wstrb_q[1])
              gwe_cnt_q <= wdata_q[`SMC_TIM_GWE_HI:`SMC_TIM_GWE_LO];
          end
          `SMC_ADDR_PIN_MODE: begin
            if (wstrb_q[0])
              pin_mode_q <= wdata_q[NPIN-1:0];
          end
          default: bresp_q <= `SMC_RESP_SLVERR;
        endcase
      end
    end
  end

  // read path: one read at a time, answer the cycle after address
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= `SMC_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      case (s_axi_araddr)
        `SMC_ADDR_CTRL: rdata_q <= ctrl_q;
        `SMC_ADDR_STATUS: begin
          rdata_q[`SMC_ST_STATE_HI:`SMC_ST_STATE_LO] <= state_q;
          rdata_q[`SMC_ST_AWAKE] <= awake_q;
          rdata_q[`SMC_ST_REQ] <= req_out_q;
          rdata_q[`SMC_ST_GWE] <= wp_q;
          rdata_q[`SMC_ST_GTS] <= gts_q;
          rdata_q[`SMC_ST_DISABLE] <= dis_q;
        end
        `SMC_ADDR_IRQ_STAT: rdata_q[`SMC_EV_W-1:0] <= irq_stat_q;
        `SMC_ADDR_IRQ_MASK: rdata_q[`SMC_EV_W-1:0] <= irq_mask_q;
        `SMC_ADDR_WAKE_EN: rdata_q[NWAKE-1:0] <= wake_en_q;
        `SMC_ADDR_TIMING: begin
          rdata_q[`SMC_TIM_GTS_HI:`SMC_TIM_GTS_LO] <= gts_cnt_q;
          rdata_q[`SMC_TIM_GWE_HI:`SMC_TIM_GWE_LO] <= gwe_cnt_q;
        end
        `SMC_ADDR_PIN_MODE: rdata_q[NPIN-1:0] <= pin_mode_q;
        default: rresp_q <= `SMC_RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule // smc_top

// >>> verification/smc_top_sva.sv
/*
  checker for the suspend mode controller top: entry, lockdown and release.
  assumes default wake timing counts and one clock with sync active-low reset.
*/
`timescale 1ns/100ps
module smc_top_sva #(
  parameter NPIN = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire sleep_pin,
  input wire sleep_ack_in,
  input wire sleep_req_out,
  input wire awake_pin,
  input wire config_done,
  input wire write_protect,
  input wire input_disable,
  input wire sleep_outputs_active,
  input wire [NPIN-1:0] pin_sleep_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // entry and the state held while asleep
  a_done_high: assert property (config_done)
    else $error("config done dropped");
  a_enter_together: assert property ($fell(awake_pin) |->
    write_protect && input_disable && sleep_outputs_active)
    else $error("sleep entry not simultaneous");
  a_asleep_locked: assert property (!awake_pin |-> write_protect)
    else $error("storage live while asleep");
  // inputs come back one cycle before awake, never while fully asleep
  a_inputs_release: assert property ($fell(input_disable) |-> !awake_pin ##1 awake_pin)
    else $error("inputs released outside the wake sequence");
  a_pin_mode_gated: assert property (!sleep_outputs_active |-> pin_sleep_mode == '0)
    else $error("pin sleep mode outside sleep");
  a_enter_needs_pin: assert property ($fell(awake_pin) |-> $past(sleep_pin, 3))
    else $error("sleep without request");
  a_ack_before_sleep: assert property ($fell(awake_pin) && $past(sleep_req_out) |->
    $past(sleep_ack_in, 2))
    else $error("sleep before acknowledge");
  a_req_needs_pin: assert property ($rose(sleep_req_out) |-> $past(sleep_pin, 2))
    else $error("request out without pin");
  a_exit_after_release: assert property ($rose(awake_pin) |-> !$past(sleep_pin, 2))
    else $error("wake while request held");
  // release timers count from the awake rise; the pins go first
  a_gts_release: assert property ($rose(awake_pin) |->
    sleep_outputs_active[*3] ##[1:3] !sleep_outputs_active)
    else $error("pin release timing");
  a_gwe_release: assert property ($rose(awake_pin) |->
    write_protect[*4] ##[1:3] !write_protect)
    else $error("write protect release timing");
  a_gwe_after_gts: assert property ($fell(write_protect) |->
    !sleep_outputs_active && !$past(sleep_outputs_active))
    else $error("storage released before pins");
  c_entry: cover property ($fell(awake_pin));
  c_request: cover property ($rose(sleep_req_out));
  c_exit: cover property ($rose(awake_pin));
endmodule // smc_top_sva
bind smc_top smc_top_sva #(.NPIN(NPIN)) u_sva (
  .aclk, .aresetn, .sleep_pin, .sleep_ack_in, .sleep_req_out, .awake_pin,
  .config_done, .write_protect, .input_disable, .sleep_outputs_active, .pin_sleep_mode
);

// >>> verification/smc_sys_model.sv
/*
  system controller and application model: sleep pin, wake pins, acknowledge.
  assumes bench commands change after a clock edge.
*/
`timescale 1ns/100ps
module smc_sys_model (
  input wire aclk,
  input wire aresetn,
  input wire want_sleep,
  input wire [7:0] want_wake,
  input wire ack_on,
  input wire sleep_req_out,
  output logic sleep_pin,
  output logic [7:0] wake_control_pins,
  output logic sleep_ack_in
);
  logic [2:0] work_q;
  // pins move on the clock; ack waits for eight cycles of pre-sleep work
  always @(posedge aclk) begin
    sleep_pin <= aresetn & want_sleep;
    wake_control_pins <= want_wake;
    work_q <= sleep_req_out ? work_q + 3'h1 : 3'h0;
    sleep_ack_in <= ack_on & sleep_req_out & (sleep_ack_in | work_q == 3'h7);
  end
endmodule // smc_sys_model

// >>> verification/suspend_mode_controller_tb_top.sv
/*
  bench for the suspend mode controller: register access, sleep entry in
  plain, handshake and multi-pin modes, release timing and interrupt.
  assumes the system model drives the sleep, wake and acknowledge pins.
*/
`timescale 1ns/100ps
`include "smc_regs.vh"
module suspend_mode_controller_tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, want_wake = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic want_sleep = 1'h0, ack_on = 1'h0;
  wire awready, wready, bvalid, arready, rvalid, sleep_pin, sleep_ack_in, irq;
  wire sleep_req_out, awake_pin, config_done, write_protect, input_disable;
  wire sleep_outputs_active;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] wake_control_pins, pin_sleep_mode;
  int fails = 0, n_checks = 0, cyc = 0;
  smc_top uut (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sleep_pin, .wake_control_pins, .sleep_ack_in, .sleep_req_out, .awake_pin,
    .config_done, .write_protect, .input_disable, .sleep_outputs_active,
    .pin_sleep_mode, .irq
  );
  smc_sys_model sys (
    .aclk, .aresetn, .want_sleep, .want_wake, .ack_on, .sleep_req_out,
    .sleep_pin, .wake_control_pins, .sleep_ack_in
  );
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", `SMC_RESP_OKAY, bresp);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk("rdata", e, rdata);
    chk("rresp", r, rresp);
    @(posedge aclk);
  endtask
  // bounded wait; the pins pass a synchroniser, so latency is a few cycles
  task automatic wawake(input logic v);
    for (int i = 0; i < 60 && awake_pin !== v; i++) @(posedge aclk);
    chk("awake_pin", v, awake_pin);
  endtask
  task automatic sleep_cycle(input logic [31:0] c);
    int n;
    int m;
    wr(`SMC_ADDR_CTRL, c);
    want_sleep <= 1'h1;
    if (c[`SMC_CTRL_SYNC]) begin
      tick(15);
      chk("sleep_req_out", 1, sleep_req_out);
      chk("held_awake", 1, awake_pin);
      ack_on <= 1'h1;
    end
    wawake(1'h0);
    tick(2);
    chk("lockdown", 32'h7, {write_protect, input_disable, sleep_outputs_active});
    chk("pin_sleep_mode", 32'hA5, pin_sleep_mode);
    chk("config_done", 1, config_done);
    rd(`SMC_ADDR_STATUS, {24'h0, 3'h7, c[`SMC_CTRL_SYNC], 1'h0, 3'h2}, `SMC_RESP_OKAY);
    chk("irq", 1, irq);
    wr(`SMC_ADDR_IRQ_STAT, 32'h7);
    chk("irq_clear", 0, irq);
    want_sleep <= 1'h0;
    if (c[`SMC_CTRL_MULTI]) begin
      want_wake <= 8'h08;
      tick(20);
      chk("still_asleep", 0, awake_pin);
      want_wake <= 8'h04;
    end
    wawake(1'h1);
    n = 0;
    while (sleep_outputs_active === 1'h1 && n < 20) begin
      tick(1);
      n++;
    end
    m = n;
    while (write_protect === 1'h1 && m < 20) begin
      tick(1);
      m++;
    end
    chk("gts_count", `SMC_GTS_DEFAULT, n);
    chk("gwe_count", `SMC_GWE_DEFAULT, m);
    chk("irq_masked", 0, irq);
    want_wake <= 8'h00;
    ack_on <= 1'h0;
    tick(10);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    forever #5 aclk = ~aclk;
  end
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    tick(20);
    aresetn <= 1'h1;
    rd(`SMC_ADDR_CTRL, `SMC_CTRL_RESET, `SMC_RESP_OKAY);
    rd(`SMC_ADDR_TIMING, {20'h0, `SMC_GWE_DEFAULT, 4'h0, `SMC_GTS_DEFAULT}, 2'h0);
    rd(8'h40, 32'h0, `SMC_RESP_SLVERR);
    wr(`SMC_ADDR_PIN_MODE, 32'hA5);
    wr(`SMC_ADDR_IRQ_MASK, 32'h1);
    wr(`SMC_ADDR_WAKE_EN, 32'h4);
    want_sleep <= 1'h1;
    tick(30);
    chk("disabled", 1, awake_pin);
    want_sleep <= 1'h0;
    tick(10);
    sleep_cycle(32'h1);
    sleep_cycle(32'h3);
    sleep_cycle(32'h5);
    tally_and_finish();
  end
endmodule // suspend_mode_controller_tb_top
